// file: common/i2cbr_pkg.sv
package i2cbr_pkg;

  // Byte addresses of the register words on the bus
  localparam logic [7:0] REG_OWN_ADDR   = 8'h00;
  localparam logic [7:0] REG_DIVIDER    = 8'h04;
  localparam logic [7:0] REG_CONTROL    = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] REG_TX_DATA    = 8'h18;
  localparam logic [7:0] REG_BUS_STATE  = 8'h1C;

  // Field positions of the divider register
  localparam int RATE_MULTIPLIER_SEL_MSB = 7;
  localparam int RATE_MULTIPLIER_SEL_LSB = 6;
  localparam int ICR_MSB  = 5;

  // Field positions of the control register
  localparam int CTRL_ENABLE = 7;
  localparam int CTRL_MASTER = 5;
  localparam int CTRL_RSTART = 2;

  // Event bits, shared by status, clear and enable
  localparam int IRQ_ADDRESSED = 0;
  localparam int IRQ_ARB_LOST  = 1;
  localparam int IRQ_BYTE_DONE = 2;
  localparam int IRQ_W         = 3;

  // Own address sits in bits 7:1, bit 0 is the direction bit
  localparam int ADDR_LSB = 1;

  // Bit slots within one byte frame
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] AFTER_ACK = 4'h9;

  // Widths of the timing counters
  localparam int CNT_W  = 14;
  localparam int DIV_W  = 12;
  localparam int HOLD_W = 10;

  // Serial clock divider, indexed by the clock rate index
  localparam logic [DIV_W-1:0] DIV_TABLE [64] = '{
    12'h014, 12'h016, 12'h018, 12'h01A, 12'h01C, 12'h01E, 12'h022, 12'h028,
    12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h044,
    12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h058, 12'h068, 12'h080,
    12'h050, 12'h060, 12'h070, 12'h080, 12'h090, 12'h0A0, 12'h0C0, 12'h0F0,
    12'h0A0, 12'h0C0, 12'h0E0, 12'h100, 12'h120, 12'h140, 12'h180, 12'h1E0,
    12'h140, 12'h180, 12'h1C0, 12'h200, 12'h240, 12'h280, 12'h300, 12'h3C0,
    12'h280, 12'h300, 12'h380, 12'h400, 12'h480, 12'h500, 12'h600, 12'h780,
    12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'hA00, 12'hC00, 12'hF00
  };

  // Data hold value in bus clock periods, same index
  localparam logic [HOLD_W-1:0] HOLD_TABLE [64] = '{
    10'h007, 10'h007, 10'h008, 10'h008, 10'h009, 10'h009, 10'h00A, 10'h00A,
    10'h007, 10'h007, 10'h009, 10'h009, 10'h00B, 10'h00B, 10'h00D, 10'h00D,
    10'h009, 10'h009, 10'h00D, 10'h00D, 10'h011, 10'h011, 10'h015, 10'h015,
    10'h009, 10'h009, 10'h011, 10'h011, 10'h019, 10'h019, 10'h021, 10'h021,
    10'h011, 10'h011, 10'h021, 10'h021, 10'h031, 10'h031, 10'h041, 10'h041,
    10'h021, 10'h021, 10'h041, 10'h041, 10'h061, 10'h061, 10'h081, 10'h081,
    10'h041, 10'h041, 10'h081, 10'h081, 10'h0C1, 10'h0C1, 10'h101, 10'h101,
    10'h081, 10'h081, 10'h101, 10'h101, 10'h181, 10'h181, 10'h201, 10'h201
  };

  // Multiplier code to shift count; the reserved code acts as factor one
  function automatic logic [1:0] rate_multiplier_sel_shift(input logic [1:0] sel);
    unique case (sel)
      2'h0:    rate_multiplier_sel_shift = 2'h0;
      2'h1:    rate_multiplier_sel_shift = 2'h1;
      2'h2:    rate_multiplier_sel_shift = 2'h2;
      default: rate_multiplier_sel_shift = 2'h0;
    endcase
  endfunction

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cbr_bus_t;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_HIGH, M_PARK, M_RESTART, M_STOP_LOW, M_STOP_HIGH
  } i2cbr_mstate_t;

  typedef struct packed {
    logic [7:0]        own_slave_address;
    logic [7:0]        bit_rate_divider;
    logic              enable;
    logic [7:0]        tx_byte;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_enable;
    logic              ack;
    logic [7:0]        rdata;
    logic              scl_prev;
    logic              sda_prev;
    logic              busy;
    i2cbr_mstate_t     mst;
    logic              master;
    logic [CNT_W-1:0]  cnt;
    logic [3:0]        bitn;
    logic [7:0]        shreg;
    logic              rxack;
    logic              scl_drive;
    logic              sda_drive;
    logic              sda_pend;
    logic              hold_run;
    logic [HOLD_W-1:0] hold_cnt;
    logic              sl_active;
    logic [3:0]        sl_bitn;
    logic [7:0]        sl_shreg;
    logic              srw;
  } i2cbr_state_t;

  // Registers reset to zero; line samples start high so no false edge follows reset
  localparam i2cbr_state_t ST_RST = '{scl_prev: 1'b1, sda_prev: 1'b1, mst: M_IDLE, default: '0};

endpackage

// file: rtl/i2cbr_core.sv
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module i2cbr_core
  import i2cbr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        light_stop_i,
  input  wire logic        deep_stop_i,
  input  wire i2cbr_bus_t  bus_i,
  output i2cbr_bus_t       bus_o,
  output i2cbr_bus_t       bus_oe_o
);

  i2cbr_state_t       st;
  i2cbr_state_t       next_st;
  logic [1:0]         rate_multiplier_sel;
  logic [5:0]         clock_rate_index;
  logic [CNT_W-1:0]   full_div;
  logic [CNT_W-1:0]   half_m1;
  logic [HOLD_W-1:0]  hold_val;
  logic               scl_fall;
  logic               scl_rise;
  logic               start_seen;
  logic               stop_seen;
  logic               addr_match;
  logic               wr_take;
  logic               rd_take;
  logic               ctrl_wr;
  logic               cmd_start;
  logic               cmd_stop;
  logic               cmd_rstart;
  logic [7:0]         rd_val;
  logic [IRQ_W-1:0]   ev;
  logic [IRQ_W-1:0]   clr;

  // Rate lookup: one clock rate index selects the divider and the hold value from their two tables
  assign rate_multiplier_sel = st.bit_rate_divider[RATE_MULTIPLIER_SEL_MSB:RATE_MULTIPLIER_SEL_LSB];
  assign clock_rate_index    = st.bit_rate_divider[ICR_MSB:0];
  assign full_div = CNT_W'(DIV_TABLE[clock_rate_index]) << rate_multiplier_sel_shift(rate_multiplier_sel);
  assign half_m1  = (full_div >> 1) - 14'h0001;
  assign hold_val = HOLD_TABLE[clock_rate_index];

  // Line events, judged against last cycle's sample of the shared lines
  assign scl_fall   = st.scl_prev & ~bus_i.scl;
  assign scl_rise   = ~st.scl_prev & bus_i.scl;
  assign start_seen = bus_i.scl & st.scl_prev & st.sda_prev & ~bus_i.sda;
  assign stop_seen  = bus_i.scl & st.scl_prev & ~st.sda_prev & bus_i.sda;
  assign addr_match = st.sl_shreg[7:ADDR_LSB] == st.own_slave_address[7:ADDR_LSB];

  // Bus slave: a write commits at the edge where ack is seen high
  assign rd_take    = cyc_i & stb_i & ~st.ack;
  assign wr_take    = cyc_i & stb_i & we_i & st.ack & sel_i[0];
  assign ctrl_wr    = wr_take && (adr_i == REG_CONTROL);
  assign cmd_start  = ctrl_wr && dat_i[CTRL_MASTER] && dat_i[CTRL_ENABLE] && !st.master;
  assign cmd_stop   = ctrl_wr && !dat_i[CTRL_MASTER] && st.master;
  assign cmd_rstart = ctrl_wr && dat_i[CTRL_MASTER] && dat_i[CTRL_RSTART] && st.master;
  assign clr        = (wr_take && (adr_i == REG_IRQ_CLEAR)) ? dat_i[IRQ_W-1:0] : 3'h0;

  // Read data mux; write-only and unmapped words read as zero
  always_comb begin
    unique case (adr_i)
      REG_OWN_ADDR:   rd_val = st.own_slave_address;
      REG_DIVIDER:    rd_val = st.bit_rate_divider;
      REG_CONTROL:    rd_val = {st.enable, 1'b0, st.master, 5'h00};
      REG_IRQ_STATUS: rd_val = {5'h00, st.irq_status};
      REG_IRQ_ENABLE: rd_val = {5'h00, st.irq_enable};
      REG_TX_DATA:    rd_val = st.tx_byte;
      REG_BUS_STATE:  rd_val = {4'h0, st.srw, st.rxack, st.master, st.busy};
      default:        rd_val = 8'h00;
    endcase
  end

  // Whole next state; power states are checked first so they override everything
  always_comb begin
    next_st = st;
    ev      = 3'h0;
    if (light_stop_i) begin
      next_st = st;
    end else if (deep_stop_i) begin
      next_st = ST_RST;
    end else begin
      next_st.scl_prev = bus_i.scl;
      next_st.sda_prev = bus_i.sda;
      next_st.ack      = rd_take;
      if (rd_take) begin
        next_st.rdata = rd_val;
      end
      if (wr_take) begin
        unique case (adr_i)
          REG_OWN_ADDR:   next_st.own_slave_address = dat_i[7:0];
          REG_DIVIDER:    next_st.bit_rate_divider = dat_i[7:0];
          REG_CONTROL:    next_st.enable = dat_i[CTRL_ENABLE];
          REG_IRQ_ENABLE: next_st.irq_enable = dat_i[IRQ_W-1:0];
          REG_TX_DATA:    next_st.tx_byte = dat_i[7:0];
          default: begin
          end
        endcase
      end

      // Busy tracking follows the lines whoever drives them; slave framing starts only while not master, and a stop ends it in either role
      if (start_seen) begin
        next_st.busy = 1'b1;
        if (!st.master) begin
          next_st.sl_active = 1'b1;
          next_st.sl_bitn   = 4'h0;
        end
      end
      if (stop_seen) begin
        next_st.busy      = 1'b0;
        next_st.sl_active = 1'b0;
        if (!st.master) begin
          next_st.sda_drive = 1'b0;
          next_st.hold_run  = 1'b0;
        end
      end

      // Pending data change matures after the hold value has run out
      if (st.hold_run) begin
        if (st.hold_cnt <= 10'h001) begin
          next_st.sda_drive = st.sda_pend;
          next_st.hold_run  = 1'b0;
        end else begin
          next_st.hold_cnt = st.hold_cnt - 10'h001;
        end
      end

      // Slave: shift the calling address, then acknowledge a match
      if (!st.master && st.sl_active) begin
        if (scl_rise && (st.sl_bitn < DATA_BITS)) begin
          next_st.sl_shreg = {st.sl_shreg[6:0], bus_i.sda};
          next_st.sl_bitn  = st.sl_bitn + 4'h1;
        end
        if (scl_fall && (st.sl_bitn == DATA_BITS)) begin
          if (addr_match && st.enable) begin
            ev[IRQ_ADDRESSED] = 1'b1;
            next_st.srw       = st.sl_shreg[0];
            next_st.sl_bitn   = AFTER_ACK;
            next_st.sda_pend  = 1'b1;
            next_st.hold_run  = 1'b1;
            next_st.hold_cnt  = hold_val;
          end else begin
            next_st.sl_active = 1'b0;
          end
        end else if (scl_fall && (st.sl_bitn == AFTER_ACK)) begin
          // Data phase is not handled here, so release after the acknowledge
          next_st.sda_pend  = 1'b0;
          next_st.hold_run  = 1'b1;
          next_st.hold_cnt  = hold_val;
          next_st.sl_active = 1'b0;
        end
      end

      // Master: place the next data bit a hold time after the clock fell
      if (scl_fall && st.master && (st.mst == M_LOW)) begin
        next_st.sda_pend = (st.bitn < DATA_BITS) ? ~st.shreg[7] : 1'b0;
        next_st.hold_run = 1'b1;
        next_st.hold_cnt = hold_val;
      end

      // Half period counter runs down by itself; states reload it
      if (st.cnt != 14'h0000) begin
        next_st.cnt = st.cnt - 14'h0001;
      end

      unique case (st.mst)
        M_IDLE: begin
          if (cmd_start) begin
            if (st.busy) begin
              ev[IRQ_ARB_LOST] = 1'b1;
            end else begin
              next_st.master    = 1'b1;
              next_st.mst       = M_START;
              next_st.sda_drive = 1'b1;
              next_st.hold_run  = 1'b0;
              next_st.cnt       = half_m1;
              next_st.shreg     = st.tx_byte;
            end
          end
        end
        M_START: begin
          if (st.cnt == 14'h0000) begin
            next_st.scl_drive = 1'b1;
            next_st.mst       = M_LOW;
            next_st.bitn      = 4'h0;
            next_st.cnt       = half_m1;
          end
        end
        M_LOW: begin
          if (st.cnt == 14'h0000) begin
            next_st.scl_drive = 1'b0;
            next_st.mst       = M_HIGH;
            next_st.cnt       = half_m1;
          end
        end
        M_HIGH: begin
          if (!bus_i.scl) begin
            // Another party still holds the clock low: the high half waits for it
            next_st.cnt = half_m1;
          end else if ((st.bitn < DATA_BITS) && !st.sda_drive && !bus_i.sda) begin
            next_st.master    = 1'b0;
            next_st.mst       = M_IDLE;
            next_st.scl_drive = 1'b0;
            next_st.sda_drive = 1'b0;
            next_st.hold_run  = 1'b0;
            ev[IRQ_ARB_LOST]  = 1'b1;
          end else if (st.cnt == 14'h0000) begin
            next_st.scl_drive = 1'b1;
            next_st.cnt       = half_m1;
            if (st.bitn == DATA_BITS) begin
              next_st.rxack    = bus_i.sda;
              next_st.mst      = M_PARK;
              ev[IRQ_BYTE_DONE] = 1'b1;
            end else begin
              next_st.mst   = M_LOW;
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.bitn  = st.bitn + 4'h1;
            end
          end
        end
        M_PARK: begin
          // Clock held low until software asks for stop or repeated start
          if (cmd_stop) begin
            next_st.mst       = M_STOP_LOW;
            next_st.sda_drive = 1'b1;
            next_st.hold_run  = 1'b0;
            next_st.cnt       = half_m1;
          end else if (cmd_rstart) begin
            next_st.mst       = M_RESTART;
            next_st.sda_drive = 1'b0;
            next_st.hold_run  = 1'b0;
            next_st.cnt       = half_m1;
          end
        end
        M_RESTART: begin
          if (st.scl_drive) begin
            if (st.cnt == 14'h0000) begin
              next_st.scl_drive = 1'b0;
              next_st.cnt       = half_m1;
            end
          end else if (!bus_i.scl) begin
            next_st.cnt = half_m1;
          end else if (st.cnt == 14'h0000) begin
            next_st.mst       = M_START;
            next_st.sda_drive = 1'b1;
            next_st.cnt       = half_m1;
            next_st.shreg     = st.tx_byte;
          end
        end
        M_STOP_LOW: begin
          if (st.cnt == 14'h0000) begin
            next_st.scl_drive = 1'b0;
            next_st.mst       = M_STOP_HIGH;
            next_st.cnt       = half_m1;
          end
        end
        M_STOP_HIGH: begin
          if (!bus_i.scl) begin
            next_st.cnt = half_m1;
          end else if (st.cnt == 14'h0000) begin
            next_st.sda_drive = 1'b0;
            next_st.master    = 1'b0;
            next_st.mst       = M_IDLE;
          end
        end
      endcase

      // Sticky events: a new event beats a clear in the same cycle
      next_st.irq_status = (st.irq_status & ~clr) | ev;
    end
  end

  // Single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Open drain: data is always low, the enable decides pull or release
  assign bus_o    = 2'b00;
  assign bus_oe_o = '{scl: st.scl_drive, sda: st.sda_drive};
  assign dat_o    = {24'h000000, st.rdata};
  assign ack_o    = st.ack;
  // No wait input exists: the level interrupt holds through light stop; deep stop resets the status that drives it
  assign irq_o    = |(st.irq_status & st.irq_enable);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_arb_cause;
    st.master && (st.mst == M_HIGH) && bus_i.scl && (st.bitn < DATA_BITS) &&
      !st.sda_drive && !bus_i.sda && !light_stop_i && !deep_stop_i;
  endsequence

  sequence s_addr_hit;
    !st.master && st.sl_active && (st.sl_bitn == DATA_BITS) && scl_fall && addr_match &&
      st.enable && !light_stop_i && !deep_stop_i;
  endsequence

  sequence s_ack_driven;
    (st.sl_bitn == AFTER_ACK) ##[1:600] bus_oe_o.sda;
  endsequence

  a_arb_switch: assert property (s_arb_cause |=> !st.master && st.irq_status[IRQ_ARB_LOST] && !bus_oe_o.scl)
    else $error("arbitration loss did not drop master mode");
  a_addr_ack: assert property (s_addr_hit |=> st.irq_status[IRQ_ADDRESSED] ##0 s_ack_driven)
    else $error("matching address not flagged and acknowledged");
  a_addr_irq: assert property (s_addr_hit && st.irq_enable[IRQ_ADDRESSED] |=> irq_o)
    else $error("address match did not interrupt");
  a_open_drain: assert property ((bus_o == 2'b00) && (!bus_oe_o.scl || st.master))
    else $error("line driven high or clock pulled while not master");
  a_hold_delay: assert property (disable iff (rst_i || deep_stop_i) $rose(bus_oe_o.scl) |=> $stable(bus_oe_o.sda)[*6])
    else $error("data changed inside the hold time");
  a_scl_low_min: assert property (disable iff (rst_i || deep_stop_i) $rose(bus_oe_o.scl) |=> bus_oe_o.scl[*8])
    else $error("clock low half too short");
  a_high_wait: assert property (st.master && (st.mst == M_HIGH) && !bus_i.scl && !light_stop_i && !deep_stop_i |=> st.cnt == $past(half_m1))
    else $error("high half counted while clock low");
  a_rate_table: assert property (((st.bit_rate_divider != 8'h0B) || (half_m1 == 14'h0013)) && ((st.bit_rate_divider != 8'h7F) || (half_m1 == 14'h0EFF)))
    else $error("divider lookup wrong");
  a_light_freeze: assert property (light_stop_i |=> st == $past(st))
    else $error("state changed in light stop");
  a_deep_reset: assert property (deep_stop_i && !light_stop_i |=> (st.own_slave_address == 8'h00) && (st.bit_rate_divider == 8'h00) && !bus_oe_o.sda)
    else $error("deep stop did not reset registers");
  a_start_busy: assert property (start_seen && !light_stop_i && !deep_stop_i |=> st.busy)
    else $error("start not seen as busy");
  a_ack_pulse: assert property (st.ack && !light_stop_i |=> !st.ack)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// file: testbench/i2cbr_peer.sv
`timescale 1ns/100ps
`default_nettype none
// Far-side bus device: pulls lines low only, acks bytes it hears, can send one byte
module i2cbr_peer
  import i2cbr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  input  wire i2cbr_bus_t line_i,
  output i2cbr_bus_t      pull_o,
  output logic            acked_o
);
  i2cbr_bus_t prev = 2'h3;
  i2cbr_bus_t mp   = 2'h0;
  logic [3:0] rises = 4'h0;
  logic       ackp  = 1'b0;
  logic       mst   = 1'b0;
  initial acked_o = 1'b0;
  assign pull_o = '{scl: mp.scl, sda: mp.sda | ackp};
  // Counts clock rises after a start; pulls the ninth slot as receiver only
  always @(posedge clk_i) begin
    prev <= line_i;
    if (prev.scl && line_i.scl && prev.sda && !line_i.sda) rises <= 4'h0;
    else if (!prev.scl && line_i.scl) rises <= rises + 4'h1;
    if (prev.scl && !line_i.scl) ackp <= !mst && (rises == 4'h8);
  end
  task automatic half();
    repeat (40) @(posedge clk_i);
  endtask
  // Start, eight bits MSB first, released ack slot, then stop
  always @(posedge go_i) begin
    mst <= 1'b1;
    mp.sda <= 1'b1;
    half();
    for (int i = 8; i >= 0; i--) begin
      mp.scl <= 1'b1;
      half();
      mp.sda <= (i > 0) ? !byte_i[i-1] : 1'b0;
      half();
      mp.scl <= 1'b0;
      half();
      if (i == 0) acked_o <= !line_i.sda;
    end
    mp <= 2'h3;
    half();
    mp.scl <= 1'b0;
    half();
    mp.sda <= 1'b0;
    mst <= 1'b0;
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import i2cbr_pkg::*;
();
  logic       clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
  logic       light_stop_i = 0, deep_stop_i = 0, ack_o, irq_o, acked;
  logic [7:0] adr_i = 8'h00, pb = 8'h00, v;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  i2cbr_bus_t bus_o, oe, pull, line, lp, op;
  i2cbr_bus_t jam = 2'h0;
  int         failures = 0, samples_checked = 0, seed = 27;
  int         cyc_n = 0, t_fall = 0, falls = 0, per = 0, hold = 0, e;
  // A third party on the wire can hold either line low
  assign line = ~(oe | pull | jam);
  i2cbr_core dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .irq_o, .light_stop_i, .deep_stop_i, .bus_i(line), .bus_o(bus_o),
    .bus_oe_o(oe));
  i2cbr_peer peer_u (.clk_i, .go_i(go), .byte_i(pb), .line_i(line), .pull_o(pull),
    .acked_o(acked));
  initial forever #50 clk_i = ~clk_i;
  // Measures clock period between clock falls and delay of the block's data changes
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    lp <= line;
    op <= oe;
    if (lp.scl && !line.scl) begin
      falls <= falls + 1;
      t_fall <= cyc_n;
      if (falls > 1 && falls < 8) per <= cyc_n - t_fall;
    end
    if (op.sda != oe.sda && falls > 0 && falls < 8) hold <= cyc_n - t_fall;
  end
  function automatic int exp_div(input logic [5:0] i);
    int d[16] = '{20, 22, 24, 26, 28, 30, 34, 40, 28, 32, 36, 40, 44, 48, 56, 68};
    return (i == 6'h3F) ? 3840 : d[i[3:0]];
  endfunction
  function automatic int exp_hold(input logic [5:0] i);
    int h[16] = '{7, 7, 8, 8, 9, 9, 10, 10, 7, 7, 9, 9, 11, 11, 13, 13};
    return (i == 6'h3F) ? 513 : h[i[3:0]];
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One classic cycle; held until ack is sampled high, read data taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (n == 100) failures++;
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    wb(0, a, 8'h00);
    check(nm, rd, ex);
  endtask
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    do begin
      wb(0, REG_IRQ_STATUS, 8'h00);
      n++;
    end while (rd[b] !== 1'b1 && n < 30000);
    if (n == 30000) failures++;
  endtask
  task automatic kick(input logic [7:0] b);
    pb <= b;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
  endtask
  // Block as master: byte out, then stop; timing checked against the tables
  task automatic master(input logic [1:0] m, input logic [5:0] i);
    wb(1, REG_DIVIDER, {m, i});
    wb(1, REG_TX_DATA, 8'hA4);
    falls = 0;
    wb(1, REG_CONTROL, 8'hA0);
    wait_irq(IRQ_BYTE_DONE);
    e = ((m == 2'h3) ? 1 : (1 << m)) * exp_div(i);
    check("period", per >= e && per <= e + 3, 1);
    check("hold", hold >= exp_hold(i) && hold <= exp_hold(i) + 2, 1);
    wb(0, REG_BUS_STATE, 8'h00);
    check("busy master ack", rd[2:0], 3'h3);
    wb(1, REG_IRQ_CLEAR, 8'h04);
    if (m == 2'h1) begin
      // Repeated start from park sends the byte again
      wb(1, REG_CONTROL, 8'hA4);
      wait_irq(IRQ_BYTE_DONE);
      wb(0, REG_BUS_STATE, 8'h00);
      check("rstart", rd[2:0], 3'h3);
      wb(1, REG_IRQ_CLEAR, 8'h04);
    end
    wb(1, REG_CONTROL, 8'h80);
    repeat (2 * e + 50) @(posedge clk_i);
    wb(0, REG_BUS_STATE, 8'h00);
    check("after stop", rd[1:0], 2'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rc("own", REG_OWN_ADDR, 0);
    rc("div", REG_DIVIDER, 0);
    rc("unmapped", 8'h40, 0);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h0B : (i == 1) ? 8'h7F : 8'($random(seed));
      wb(1, REG_DIVIDER, v);
      rc("div rw", REG_DIVIDER, {24'h0, v});
    end
    wb(1, REG_DIVIDER, 8'h00);
    wb(1, REG_OWN_ADDR, 8'h5A);
    wb(1, REG_IRQ_ENABLE, 8'h07);
    wb(1, REG_CONTROL, 8'h80);
    kick(8'h5B);
    repeat (1500) @(posedge clk_i);
    check("slave ack", acked, 1);
    check("irq", irq_o, 1);
    rc("status", REG_IRQ_STATUS, 32'h1);
    rc("srw", REG_BUS_STATE, 32'h8);
    wb(1, REG_IRQ_CLEAR, 8'h01);
    @(posedge clk_i);
    check("irq clr", irq_o, 0);
    v = 8'($random(seed));
    kick(8'h5A ^ {v[7:2], 1'b1, v[0]});
    repeat (200) @(posedge clk_i);
    wb(1, REG_CONTROL, 8'hA0);
    repeat (1400) @(posedge clk_i);
    check("no ack", acked, 0);
    rc("arb status", REG_IRQ_STATUS, 32'h2);
    rc("to slave", REG_CONTROL, 32'h80);
    check("arb irq", irq_o, 1);
    wb(1, REG_IRQ_ENABLE, 8'h05);
    @(posedge clk_i);
    check("masked", irq_o, 0);
    wb(1, REG_IRQ_CLEAR, 8'h02);
    // Another party holds both lines mid-bit: clock stretch first, then lost arbitration
    wb(1, REG_TX_DATA, 8'hA4);
    wb(1, REG_CONTROL, 8'hA0);
    repeat (15) @(posedge clk_i);
    jam <= 2'h3;
    repeat (30) @(posedge clk_i);
    wb(0, REG_BUS_STATE, 8'h00);
    check("stretch", rd[1:0], 2'h3);
    jam <= 2'h1;
    wait_irq(IRQ_ARB_LOST);
    check("arb release", oe, 2'h0);
    jam <= 2'h0;
    rc("arb to slave", REG_CONTROL, 32'h80);
    wb(1, REG_IRQ_CLEAR, 8'h02);
    for (int m = 0; m < 4; m++) master(m, $random(seed) & 6'h0F);
    master(2'h0, 6'h3F);
    light_stop_i <= 1;
    repeat (20) @(posedge clk_i);
    light_stop_i <= 0;
    rc("light keep", REG_OWN_ADDR, 32'h5A);
    deep_stop_i <= 1;
    @(posedge clk_i);
    deep_stop_i <= 0;
    rc("deep own", REG_OWN_ADDR, 0);
    rc("deep ctrl", REG_CONTROL, 0);
    stop_test();
  end
  // Cuts a hang short well beyond the longest frame sequence
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
